// File: design/usbf_core.sv
// serial port buffer, flag and interrupt request logic
`timescale 1ns/1ns
`include "usbf_params.svh"
module usbf_core
	import usbf_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       nrst_in,
	input  wire logic       clk_en_in,
	input  wire usbf_bus_t  bus_in,
	output logic      [7:0] rdata_out,
	input  wire logic       serial_in_pin_in,
	input  wire logic       ext_xfer_clock_pin_in,
	output logic            serial_out_pin_out,
	output logic            serial_out_oe_n_out,
	output logic            rx_pin_owned_out,
	output logic            irq_buf_empty_out,
	output logic            irq_tx_done_out,
	output logic            irq_rx_done_out,
	input  wire logic       irq_tx_done_ack_in
);
	logic [7:0] ctrl_b_q, ctrl_c_q;
	logic       gie_q;
	logic [7:0] tx_buf_q;
	logic       tx_buf9_q, tx_buf_full_q, tx_done_flag_q;
	logic [11:0] tx_sh_q;
	logic [3:0] tx_cnt_q;
	logic       tx_active_q;
	usbf_tx_state_t tx_st_q;
	usbf_rx_state_t rx_st_q;
	logic [1:0] rxd_sync_q, xck_sync_q;
	logic       xck_prev_q;
	logic [7:0] baud_cnt_q;
	logic       baud_tick;
	logic [3:0] rx_cnt_q;
	logic [9:0] rx_sh_q;
	logic       rx_hold_q;
	usbf_rx_entry_t rx_hold_ent_q;
	usbf_rx_entry_t fifo_q [`USBF_FIFO_DEPTH];
	logic [1:0] fifo_cnt_q;
	logic       fifo_rd_ptr_q;
	logic       dor_pend_q;
	logic       tx_en_eff_q;
	logic       is_wr_data, is_rd_data, is_wr_stat, is_wr_cb;
	logic [3:0] data_bits, frame_bits;
	logic       nine, par_en, sync_mode, tx_par, xck_rise;
	logic       rx_bit, pop, push, rx_frame_done;
	usbf_rx_entry_t head, new_ent;
	logic [8:0] rx_data_mask;
	logic [7:0] rdata_d;

	assign is_wr_data = bus_in.wr && bus_in.addr == `USBF_ADDR_DATA;
	assign is_rd_data = bus_in.rd && bus_in.addr == `USBF_ADDR_DATA;
	assign is_wr_stat = bus_in.wr && bus_in.addr == `USBF_ADDR_STATUS;
	assign is_wr_cb   = bus_in.wr && bus_in.addr == `USBF_ADDR_CTRL_B;
	assign nine       = ctrl_c_q[`USBF_CC_SZ9:0] == `USBF_SZ_NINE;
	assign data_bits  = nine ? 4'h9 : 4'h5 + {2'h0, ctrl_c_q[`USBF_CC_SZ_HI:`USBF_CC_SZ_LO]};
	assign par_en     = ctrl_c_q[`USBF_CC_PM_HI];
	assign sync_mode  = ctrl_c_q[`USBF_CC_SYNC];
	assign frame_bits = data_bits + {3'h0, par_en};

	// synchronisers for pins
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rxd_sync_q <= 2'h3;
			xck_sync_q <= 2'h0;
			xck_prev_q <= 1'b0;
		end else if (clk_en_in) begin
			rxd_sync_q <= {rxd_sync_q[0], serial_in_pin_in};
			xck_sync_q <= {xck_sync_q[0], ext_xfer_clock_pin_in};
			xck_prev_q <= xck_sync_q[1];
		end
	end
	assign xck_rise = xck_sync_q[1] && !xck_prev_q;

	// internal baud tick
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			baud_cnt_q <= 8'h00;
		end else if (clk_en_in) begin
			baud_cnt_q <= (baud_cnt_q == `USBF_BAUD_DIV) ? 8'h00 : baud_cnt_q + 8'h01;
		end
	end
	assign baud_tick = sync_mode ? xck_rise : (baud_cnt_q == `USBF_BAUD_DIV);

	// control registers
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_b_q <= `USBF_CB_RESET;
			ctrl_c_q <= `USBF_CC_RESET;
			gie_q    <= 1'b0;
		end else if (clk_en_in && bus_in.wr) begin
			if (bus_in.addr == `USBF_ADDR_CTRL_B) begin
				ctrl_b_q <= {bus_in.wdata[7:2], ctrl_b_q[`USBF_CB_RX9], bus_in.wdata[0]};
			end
			if (bus_in.addr == `USBF_ADDR_CTRL_C) begin
				ctrl_c_q <= bus_in.wdata;
			end
			if (bus_in.addr == `USBF_ADDR_GLOBAL) begin
				gie_q <= bus_in.wdata[0];
			end
		end
	end

	// effective transmitter enable, off only once idle
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_en_eff_q <= 1'b0;
		end else if (clk_en_in) begin
			if (ctrl_b_q[`USBF_CB_TX_ENABLE_BIT]) begin
				tx_en_eff_q <= 1'b1;
			end else if (!tx_active_q && !tx_buf_full_q) begin
				tx_en_eff_q <= 1'b0;
			end
		end
	end

	// parity over data bits
	always_comb begin
		tx_par = ctrl_c_q[`USBF_CC_PM_ODD];
		for (int i = 0; i < 9; i++) begin
			if (i < int'(data_bits)) begin
				tx_par = tx_par ^ (i < 8 ? tx_buf_q[i[2:0]] : tx_buf9_q);
			end
		end
	end

	// transmit buffer, shifter and flags
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_buf_q       <= 8'h00;
			tx_buf9_q      <= 1'b0;
			tx_buf_full_q  <= 1'b0;
			tx_done_flag_q <= 1'b0;
			tx_sh_q        <= 12'hfff;
			tx_cnt_q       <= 4'h0;
			tx_active_q    <= 1'b0;
			tx_st_q        <= USBF_TX_IDLE;
		end else if (clk_en_in) begin
			if (is_wr_stat && bus_in.wdata[`USBF_ST_TXC]) begin
				tx_done_flag_q <= 1'b0;
			end
			if (irq_tx_done_ack_in) begin
				tx_done_flag_q <= 1'b0;
			end
			if (is_wr_data && tx_en_eff_q) begin
				tx_buf_q      <= bus_in.wdata;
				tx_buf9_q     <= ctrl_b_q[`USBF_CB_TX9];
				tx_buf_full_q <= 1'b1;
			end
			case (tx_st_q)
				USBF_TX_IDLE: begin
					if (tx_buf_full_q && baud_tick) begin
						// frame lsb first: start, data, parity, stop(s)
						if (par_en) begin
							tx_sh_q <= (12'hfff << (data_bits + 4'h2))
								| ({1'b0, tx_par, 10'h000} >> (4'h9 - data_bits))
								| ({3'h0, tx_buf9_q, tx_buf_q} << 1) & ~(12'hffe << data_bits);
						end else begin
							tx_sh_q <= (12'hfff << (data_bits + 4'h1))
								| ({3'h0, tx_buf9_q, tx_buf_q} << 1) & ~(12'hffe << data_bits);
						end
						tx_cnt_q      <= frame_bits + 4'h1 + {3'h0, ctrl_c_q[`USBF_CC_STOP2]};
						tx_buf_full_q <= is_wr_data && tx_en_eff_q;
						tx_active_q   <= 1'b1;
						tx_st_q       <= USBF_TX_SHIFT;
					end
				end
				USBF_TX_SHIFT: begin
					if (baud_tick) begin
						tx_sh_q <= {1'b1, tx_sh_q[11:1]};
						if (tx_cnt_q == 4'h0) begin
							tx_active_q <= 1'b0;
							tx_st_q     <= USBF_TX_IDLE;
							if (!tx_buf_full_q) begin
								tx_done_flag_q <= 1'b1;
							end
						end else begin
							tx_cnt_q <= tx_cnt_q - 4'h1;
						end
					end
				end
				default: tx_st_q <= USBF_TX_IDLE;
			endcase
		end
	end

	// receive shifter
	assign rx_bit = rxd_sync_q[1];
	assign rx_frame_done = rx_st_q == USBF_RX_SHIFT && baud_tick && rx_cnt_q == frame_bits;
	always_comb begin
		rx_data_mask  = 9'h1ff >> (4'h9 - data_bits);
		new_ent.data  = rx_sh_q[8:0] & rx_data_mask;
		new_ent.fe    = !rx_bit;
		new_ent.dor   = dor_pend_q;
		new_ent.pe    = par_en && (^(rx_sh_q[8:0] & rx_data_mask) ^ ctrl_c_q[`USBF_CC_PM_ODD]
			^ rx_sh_q[data_bits]);
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_st_q  <= USBF_RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_sh_q  <= 10'h000;
		end else if (clk_en_in) begin
			if (!ctrl_b_q[`USBF_CB_RXEN]) begin
				rx_st_q <= USBF_RX_IDLE;
			end else begin
				case (rx_st_q)
					USBF_RX_IDLE: begin
						if (baud_tick && !rx_bit) begin
							rx_st_q  <= USBF_RX_SHIFT;
							rx_cnt_q <= 4'h0;
						end
					end
					USBF_RX_SHIFT: begin
						if (baud_tick) begin
							if (rx_cnt_q == frame_bits) begin
								rx_st_q <= USBF_RX_IDLE;
							end else begin
								rx_sh_q[rx_cnt_q] <= rx_bit;
								rx_cnt_q          <= rx_cnt_q + 4'h1;
							end
						end
					end
					default: rx_st_q <= USBF_RX_IDLE;
				endcase
			end
		end
	end

	// receive FIFO with waiting slot
	assign head = fifo_q[fifo_rd_ptr_q];
	assign pop  = is_rd_data && fifo_cnt_q != 2'h0;
	assign push = rx_hold_q && (fifo_cnt_q != 2'h2 || pop);
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < `USBF_FIFO_DEPTH; i++) begin
				fifo_q[i] <= '0;
			end
			fifo_cnt_q    <= 2'h0;
			fifo_rd_ptr_q <= 1'b0;
			rx_hold_q     <= 1'b0;
			rx_hold_ent_q <= '0;
			dor_pend_q    <= 1'b0;
		end else if (clk_en_in) begin
			if (!ctrl_b_q[`USBF_CB_RXEN]) begin
				fifo_cnt_q <= 2'h0;
				rx_hold_q  <= 1'b0;
				dor_pend_q <= 1'b0;
			end else begin
				if (push) begin
					fifo_q[fifo_rd_ptr_q ^ fifo_cnt_q[0]] <= rx_hold_ent_q;
					dor_pend_q <= 1'b0;
				end
				fifo_cnt_q    <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
				fifo_rd_ptr_q <= fifo_rd_ptr_q ^ pop;
				if (rx_st_q == USBF_RX_IDLE && baud_tick && !rx_bit && rx_hold_q && !push) begin
					dor_pend_q        <= 1'b1;
					rx_hold_ent_q.dor <= 1'b1;
				end
				if (rx_frame_done && (!rx_hold_q || push)) begin
					rx_hold_ent_q <= new_ent;
					rx_hold_q     <= 1'b1;
				end else if (push) begin
					rx_hold_q <= 1'b0;
				end
			end
		end
	end

	// read data and outputs
	always_comb begin
		rdata_d = 8'h00;
		case (bus_in.addr)
			`USBF_ADDR_DATA: rdata_d = head.data[7:0];
			`USBF_ADDR_STATUS: rdata_d = {fifo_cnt_q != 2'h0, tx_done_flag_q, !tx_buf_full_q,
				head.fe, head.dor, head.pe, 2'h0};
			`USBF_ADDR_CTRL_B: rdata_d = {ctrl_b_q[7:2], head.data[8], ctrl_b_q[0]};
			`USBF_ADDR_CTRL_C: rdata_d = ctrl_c_q;
			`USBF_ADDR_GLOBAL: rdata_d = {7'h00, gie_q};
			default: rdata_d = 8'h00;
		endcase
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out           <= 8'h00;
			serial_out_pin_out  <= 1'b1;
			serial_out_oe_n_out <= 1'b1;
			rx_pin_owned_out    <= 1'b0;
			irq_buf_empty_out   <= 1'b0;
			irq_tx_done_out     <= 1'b0;
			irq_rx_done_out     <= 1'b0;
		end else if (clk_en_in) begin
			rdata_out           <= bus_in.rd ? rdata_d : 8'h00;
			serial_out_pin_out  <= tx_sh_q[0];
			serial_out_oe_n_out <= !tx_en_eff_q;
			rx_pin_owned_out    <= ctrl_b_q[`USBF_CB_RXEN];
			// error flags feed no request
			irq_buf_empty_out   <= gie_q && ctrl_b_q[`USBF_CB_UDRIE] && !tx_buf_full_q
				&& !(is_wr_data && tx_en_eff_q);
			irq_tx_done_out     <= gie_q && ctrl_b_q[`USBF_CB_TXCIE] && tx_done_flag_q
				&& !irq_tx_done_ack_in;
			irq_rx_done_out     <= gie_q && ctrl_b_q[`USBF_CB_RXCIE] && fifo_cnt_q != 2'h0
				&& ctrl_b_q[`USBF_CB_RXEN];
		end
	end

	chk_rx_flush_empty: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && !ctrl_b_q[`USBF_CB_RXEN] |=> fifo_cnt_q == 2'h0) else $error("fifo not flushed");
	chk_write_clears_empty: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && is_wr_data && tx_en_eff_q |=> tx_buf_full_q) else $error("empty flag kept");
	chk_txc_ack_clear: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && irq_tx_done_ack_in && !(tx_st_q == USBF_TX_SHIFT && baud_tick)
		|=> !tx_done_flag_q) else $error("done flag stays");
	chk_rxc_irq: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && gie_q && ctrl_b_q[`USBF_CB_RXCIE] && ctrl_b_q[`USBF_CB_RXEN] && fifo_cnt_q != 0
		|=> irq_rx_done_out) else $error("rx irq missing");
	chk_fifo_bound: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		fifo_cnt_q <= 2'h2) else $error("fifo overfilled");
	chk_tx_hold_en: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		tx_active_q |-> tx_en_eff_q) else $error("tx dropped mid frame");
	chk_pe_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && rx_frame_done && !par_en |=> !rx_hold_ent_q.pe) else $error("parity set");
	chk_udre_irq: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && !gie_q |=> !irq_buf_empty_out) else $error("irq without global");
	chk_udre_irq_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && gie_q && ctrl_b_q[`USBF_CB_UDRIE] && !tx_buf_full_q && !(is_wr_data && tx_en_eff_q)
		|=> irq_buf_empty_out) else $error("empty irq missing");
	chk_txc_irq_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && gie_q && ctrl_b_q[`USBF_CB_TXCIE] && tx_done_flag_q && !irq_tx_done_ack_in
		|=> irq_tx_done_out) else $error("done irq missing");
	chk_txc_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && tx_st_q == USBF_TX_SHIFT && baud_tick && tx_cnt_q == 4'h0 && !tx_buf_full_q
		|=> tx_done_flag_q) else $error("done flag not set");
	chk_tx_off_idle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && !ctrl_b_q[`USBF_CB_TX_ENABLE_BIT] && !tx_active_q && !tx_buf_full_q
		|=> !tx_en_eff_q) else $error("tx not released");
	chk_rx_own: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in |=> rx_pin_owned_out == $past(ctrl_b_q[`USBF_CB_RXEN])) else $error("pin owner wrong");
	chk_fe_stop: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && ctrl_b_q[`USBF_CB_RXEN] && rx_frame_done && (!rx_hold_q || push)
		|=> rx_hold_ent_q.fe != $past(rx_bit)) else $error("frame error wrong");
	chk_rxc_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && fifo_cnt_q == 2'h0 |=> !irq_rx_done_out) else $error("rx irq when empty");
	chk_push_clr_dor: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && ctrl_b_q[`USBF_CB_RXEN] && push |=> !dor_pend_q) else $error("overrun kept");
	chk_overrun_mark: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		clk_en_in && ctrl_b_q[`USBF_CB_RXEN] && rx_st_q == USBF_RX_IDLE && baud_tick && !rx_bit
		&& rx_hold_q && !push |=> rx_hold_ent_q.dor) else $error("overrun not marked");
	cov_tx_done: cover property (@(posedge core_clk_in) $rose(tx_done_flag_q));
	cov_frame_err: cover property (@(posedge core_clk_in) rx_frame_done && !rx_bit);
	cov_fifo_full: cover property (@(posedge core_clk_in) fifo_cnt_q == 2'h2);
	cov_overrun: cover property (@(posedge core_clk_in) $rose(dor_pend_q));
endmodule : usbf_core

// File: design/usbf_params.svh
// register offsets, field positions and reset values of the serial buffer block
`ifndef USBF_PARAMS_SVH
`define USBF_PARAMS_SVH
`define USBF_ADDR_DATA      3'h0
`define USBF_ADDR_STATUS    3'h1
`define USBF_ADDR_CTRL_B    3'h2
`define USBF_ADDR_CTRL_C    3'h3
`define USBF_ADDR_GLOBAL    3'h4
`define USBF_ST_RXC         7
`define USBF_ST_TXC         6
`define USBF_ST_UDRE        5
`define USBF_ST_FE          4
`define USBF_ST_DOR         3
`define USBF_ST_PE          2
`define USBF_CB_RXCIE       7
`define USBF_CB_TXCIE       6
`define USBF_CB_UDRIE       5
`define USBF_CB_RXEN        4
`define USBF_CB_TX_ENABLE_BIT        3
`define USBF_CB_RX9         1
`define USBF_CB_TX9         0
`define USBF_CB_RESET       8'h00
`define USBF_CC_RESET       8'h06
`define USBF_CC_SYNC        6
`define USBF_CC_PM_HI       5
`define USBF_CC_PM_ODD      4
`define USBF_CC_STOP2       3
`define USBF_CC_SZ_HI       2
`define USBF_CC_SZ_LO       1
`define USBF_CC_SZ9         2
`define USBF_SZ_NINE        3'h7
`define USBF_BAUD_DIV       8'h0f
`define USBF_FIFO_DEPTH     2
`endif

// File: design/usbf_pkg.sv
// types shared by the serial buffer block
package usbf_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} usbf_bus_t;
	typedef struct packed {
		logic [8:0] data;
		logic       fe;
		logic       dor;
		logic       pe;
	} usbf_rx_entry_t;
	typedef enum logic [1:0] {
		USBF_TX_IDLE,
		USBF_TX_SHIFT
	} usbf_tx_state_t;
	typedef enum logic [1:0] {
		USBF_RX_IDLE,
		USBF_RX_SHIFT
	} usbf_rx_state_t;
endpackage : usbf_pkg

// File: sim/usbf_peer.sv
// remote serial peer: frame sender and frame catcher on the line
`timescale 1ns/1ns
module usbf_peer (
	input  wire logic  clk_in,
	input  wire logic  line_in,
	output logic       line_out
);
	int unsigned  cap_len;
	logic [11:0]  cap_q;
	logic [11:0]  cap_fifo[$];
	initial begin
		line_out = 1'b1;
		cap_len = 8;
		cap_q = '0;
	end
	// start, bits lsb first, first stop at given level, then idle high
	task automatic send(input int unsigned n, input logic [10:0] bits, input logic stop);
		@(posedge clk_in);
		line_out <= 1'b0;
		repeat (16) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			line_out <= bits[i];
			repeat (16) @(posedge clk_in);
		end
		line_out <= stop;
		repeat (16) @(posedge clk_in);
		line_out <= 1'b1;
		repeat (16) @(posedge clk_in);
	endtask : send
	// mid-bit capture of data, parity and first stop
	always begin
		@(negedge line_in);
		repeat (8) @(posedge clk_in);
		for (int i = 0; i <= cap_len; i++) begin
			repeat (16) @(posedge clk_in);
			cap_q[i] = line_in;
		end
		cap_fifo.push_back(cap_q);
	end
endmodule : usbf_peer

// File: sim/test_usbf_core.sv
// self-checking bench for the serial buffer and flag logic
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %0t mismatch got %h exp %h", $time, (g), (e)); end end
module test_usbf_core
	import usbf_pkg::*;
;
	logic        clk;
	logic        nrst;
	usbf_bus_t   bus;
	logic [7:0]  rdata;
	logic        tx_line;
	logic        rx_line;
	logic        line_w;
	logic        oe_n;
	logic        rx_own;
	logic        irq_be;
	logic        irq_td;
	logic        irq_rd;
	logic        ack;
	logic [7:0]  v;
	logic [7:0]  cc;
	logic [7:0]  d;
	logic [11:0] c;
	logic [11:0] e;
	logic        o;
	int          mismatches;
	int          check_count;
	assign line_w = oe_n ? 1'b1 : tx_line;
	usbf_core u_dut (
		.core_clk_in           (clk),
		.nrst_in               (nrst),
		.clk_en_in             (1'b1),
		.bus_in                (bus),
		.rdata_out             (rdata),
		.serial_in_pin_in      (rx_line),
		.ext_xfer_clock_pin_in (1'b0),
		.serial_out_pin_out    (tx_line),
		.serial_out_oe_n_out   (oe_n),
		.rx_pin_owned_out      (rx_own),
		.irq_buf_empty_out     (irq_be),
		.irq_tx_done_out       (irq_td),
		.irq_rx_done_out       (irq_rd),
		.irq_tx_done_ack_in    (ack)
	);
	usbf_peer peer (
		.clk_in   (clk),
		.line_in  (line_w),
		.line_out (rx_line)
	);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] wd);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= wd;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] rv);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		rv = rdata;
	endtask : rd
	task automatic wait_st(input int b, input logic lv);
		logic [7:0] s;
		for (int k = 0; k < 400; k++) begin
			rd(3'h1, s);
			if (s[b] === lv)
				return;
		end
		mismatches++;
		$display("ERROR %0t status wait timed out", $time);
	endtask : wait_st
	task automatic rx_one(input logic [7:0] cf, input int n, input logic [10:0] b, input logic st,
		input logic [7:0] ed, input logic [2:0] ee);
		logic [7:0] s;
		wr(3'h3, cf);
		peer.send(n, b, st);
		wait_st(7, 1'b1);
		`CHK(irq_rd, 1'b1)
		rd(3'h1, s);
		`CHK(s[4:2], ee)
		rd(3'h2, s);
		if (cf[2:0] == 3'h7)
			`CHK(s[1], b[8])
		rd(3'h0, s);
		`CHK(s, ed)
	endtask : rx_one
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		bus = '0;
		nrst = 1'b0;
		ack = 1'b0;
		mismatches = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(3'h1, v);
		`CHK(v, 8'h20)
		`CHK(oe_n, 1'b1)
		`CHK(rx_own, 1'b0)
		rd(3'h7, v);
		wr(3'h2, 8'h68);
		repeat (3) @(negedge clk);
		`CHK(irq_be, 1'b0)
		wr(3'h4, 8'h01);
		repeat (3) @(negedge clk);
		`CHK(irq_be, 1'b1)
		`CHK(oe_n, 1'b0)
		for (int i = 0; i < 3; i++) begin
			cc = (i == 0) ? 8'h06 : (i == 1) ? 8'h26 : 8'h36;
			peer.cap_len = cc[5] ? 9 : 8;
			wr(3'h3, cc);
			wr(3'h0, 8'h5a);
			wait_st(5, 1'b1);
			wr(3'h0, 8'h83);
			rd(3'h1, v);
			`CHK(v[5], 1'b0)
			`CHK(irq_be, 1'b0)
			if (i == 2)
				wr(3'h2, 8'h60);
			`CHK(oe_n, 1'b0)
			wait_st(6, 1'b1);
			`CHK(irq_td, 1'b1)
			`CHK(peer.cap_fifo.size(), 2)
			for (int j = 0; j < 2; j++) begin
				d = j ? 8'h83 : 8'h5a;
				e = cc[5] ? {3'b001, ^d ^ cc[4], d} : {4'b0001, d};
				c = peer.cap_fifo.pop_front() & ((12'h1 << (peer.cap_len + 1)) - 12'h1);
				`CHK(c, e)
			end
			if (i == 0) begin
				@(posedge clk);
				ack <= 1'b1;
				@(posedge clk);
				ack <= 1'b0;
			end else
				wr(3'h1, 8'h40);
			repeat (2) @(negedge clk);
			rd(3'h1, v);
			`CHK(v[6], 1'b0)
		end
		`CHK(oe_n, 1'b1)
		wr(3'h2, 8'h90);
		repeat (2) @(negedge clk);
		`CHK(rx_own, 1'b1)
		rx_one(8'h06, 8, 11'h03c, 1'b1, 8'h3c, 3'h0);
		rx_one(8'h0e, 8, 11'h081, 1'b0, 8'h81, 3'h4);
		rx_one(8'h26, 9, 11'h007, 1'b1, 8'h07, 3'h1);
		rx_one(8'h36, 9, 11'h007, 1'b1, 8'h07, 3'h0);
		rx_one(8'h00, 5, 11'h01f, 1'b1, 8'h1f, 3'h0);
		rx_one(8'h07, 9, 11'h1a5, 1'b1, 8'ha5, 3'h0);
		wr(3'h3, 8'h06);
		for (int k = 0; k < 4; k++)
			peer.send(8, 11'h040 + k, 1'b1);
		wr(3'h1, 8'h1c);
		rd(3'h1, v);
		`CHK(v & 8'hfc, 8'ha0)
		o = 1'b0;
		for (int k = 0; k < 4; k++) begin
			rd(3'h1, v);
			o = o | v[3];
			if (v[7])
				rd(3'h0, v);
		end
		`CHK(o, 1'b1)
		rd(3'h1, v);
		`CHK(v[7], 1'b0)
		rx_one(8'h06, 8, 11'h0c3, 1'b1, 8'hc3, 3'h0);
		wr(3'h2, 8'h10);
		peer.send(8, 11'h055, 1'b0);
		wait_st(7, 1'b1);
		`CHK(irq_rd, 1'b0)
		wr(3'h2, 8'h00);
		rd(3'h1, v);
		`CHK(v[7], 1'b0)
		`CHK(rx_own, 1'b0)
		give_verdict();
	end
	initial begin
		#2000000;
		mismatches++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
endmodule : test_usbf_core
